// file: hdl/cmp_ctrl_pkg.sv
// package: register map, field layouts, reset values and timing for the comparator control
package cmp_ctrl_pkg;

	// -------------------------------------------------------------
	// register indices (byte address is four times the index)
	// -------------------------------------------------------------
	localparam logic [7:0] IDX_COMPARATOR_CONTROL       = 8'h00;
	localparam logic [7:0] IDX_INPUT_SELECT_CONTROL     = 8'h02;
	localparam logic [7:0] IDX_INTERRUPT_ENABLE_CONTROL = 8'h06;
	localparam logic [7:0] IDX_COMPARATOR_STATUS        = 8'h07;
	localparam logic [7:0] COMPARATOR_VECTOR            = 8'h00;

	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int CTL_ENABLE_BIT   = 0;
	localparam int CTL_HYST_LSB     = 1;
	localparam int CTL_EDGE_LSB     = 4;
	localparam int CTL_PAD_OE_BIT   = 6;
	localparam int CTL_RUNSTBY_BIT  = 7;
	localparam int MUX_NEG_LSB      = 0;
	localparam int MUX_POS_BIT      = 3;
	localparam int MUX_INVERT_BIT   = 7;
	localparam int STAT_FLAG_BIT    = 0;
	localparam int STAT_STATE_BIT   = 4;

	// -------------------------------------------------------------
	// reset values and field masks of writable bits
	// -------------------------------------------------------------
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] MUX_RESET  = 8'h00;
	localparam logic [7:0] INTE_RESET = 8'h00;
	localparam logic [7:0] CTL_MASK   = 8'hF7;
	localparam logic [7:0] MUX_MASK   = 8'h8B;
	localparam logic [7:0] INTE_MASK  = 8'h01;

	// -------------------------------------------------------------
	// encodings
	// -------------------------------------------------------------
	localparam logic [1:0] EDGE_BOTH    = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_RISING  = 2'h3;
	localparam logic [1:0] NEG_PIN_A    = 2'h0;
	localparam logic [1:0] NEG_PIN_B    = 2'h1;
	localparam logic [1:0] NEG_VREF     = 2'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		SLEEP_ACTIVE,
		SLEEP_IDLE,
		SLEEP_STANDBY,
		SLEEP_POWERDOWN
	} sleep_t;

	// -------------------------------------------------------------
	// timing: 125 MHz clock, start-up waits round up
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 8000;
	localparam int CORE_STARTUP_PS   = 2500000;
	localparam int VREF_STARTUP_PS   = 60000000;
	localparam int CORE_STARTUP_CYC  = (CORE_STARTUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int VREF_STARTUP_CYC  = (VREF_STARTUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STARTUP_CNT_W     = 13;
	localparam int SYNC_STAGES       = 2;

	// -------------------------------------------------------------
	// register layouts
	// -------------------------------------------------------------
	typedef struct packed {
		logic       run_in_standby;
		logic       pad_output_enable;
		logic [1:0] interrupt_edge_select;
		logic       unused3;
		logic [1:0] hysteresis_select;
		logic       enable;
	} comparator_control_t;

	typedef struct packed {
		logic       invert;
		logic [2:0] unused6_4;
		logic       positive_input_select;
		logic       unused2;
		logic [1:0] negative_input_select;
	} input_select_control_t;

endpackage

// file: hdl/cmp_sync.sv
// module: two-flop synchroniser for asynchronous levels
module cmp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // peripheral clock
	input  wire logic         rst_n,  // async reset, active low
	input  wire logic [W-1:0] d,      // asynchronous level
	output logic      [W-1:0] q       // synchronised level
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // cmp_sync

// file: hdl/cmp_ctrl.sv
// module: comparator control logic with AXI4-Lite register slave
module cmp_ctrl #(
	parameter int VREF_STARTUP_CYCLES = cmp_ctrl_pkg::VREF_STARTUP_CYC
) (
	input  wire logic        clk,                   // peripheral clock, 125 MHz
	input  wire logic        rst_n,                 // async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,          // write address
	input  wire logic        s_axi_awvalid,         // write address valid
	output logic             s_axi_awready,         // write address ready
	input  wire logic [31:0] s_axi_wdata,           // write data
	input  wire logic [3:0]  s_axi_wstrb,           // write strobes
	input  wire logic        s_axi_wvalid,          // write data valid
	output logic             s_axi_wready,          // write data ready
	output logic [1:0]       s_axi_bresp,           // write response
	output logic             s_axi_bvalid,          // write response valid
	input  wire logic        s_axi_bready,          // write response ready
	input  wire logic [7:0]  s_axi_araddr,          // read address
	input  wire logic        s_axi_arvalid,         // read address valid
	output logic             s_axi_arready,         // read address ready
	output logic [31:0]      s_axi_rdata,           // read data
	output logic [1:0]       s_axi_rresp,           // read response
	output logic             s_axi_rvalid,          // read data valid
	input  wire logic        s_axi_rready,          // read data ready
	input  wire logic        core_result,           // raw comparator output, async
	input  wire logic [1:0]  sleep_mode,            // sleep state, sleep_t, async
	input  wire logic        per_clk_request,       // peripheral clock held in standby, async
	output logic             core_enable,           // comparator core power-up
	output logic [1:0]       hysteresis_select,     // hysteresis level to core
	output logic             positive_input_select, // 0 pin a, 1 pin b
	output logic [1:0]       negative_input_select, // pin a, pin b, reference
	output logic             result_settled,        // start-up time elapsed
	output logic             event_out,             // unsynchronised event source
	output logic             pad_out,               // comparator output pin value
	output logic             pad_oe_n,              // pin output enable, active low
	output logic             irq                    // comparator_vector request, level
);
	// -------------------------------------------------------------
	// registers and decoding
	// -------------------------------------------------------------
	cmp_ctrl_pkg::comparator_control_t   ctl_reg;
	cmp_ctrl_pkg::input_select_control_t mux_reg;
	logic [7:0]                          inte_reg;
	logic                                flag_reg;
	logic                                flag_next;
	logic                                state_reg;
	logic                                result_sync;
	logic [3:0]                          misc_sync;
	cmp_ctrl_pkg::sleep_t                sleep_s;
	logic                                clk_held_s;
	logic                                unit_on;
	logic                                status_live;
	logic                                edge_hit;
	logic                                rise;
	logic                                fall;
	logic [cmp_ctrl_pkg::STARTUP_CNT_W-1:0] start_cnt_reg;
	logic                                active_d_reg;
	logic [7:0]                          aw_addr_reg;
	logic                                aw_have_reg;
	logic [7:0]                          w_data_reg;
	logic                                w_lane_reg;
	logic                                w_have_reg;
	logic                                do_write;
	logic                                do_read;
	logic                                stat_clear_w;
	logic                                stat_clear_r;

	function automatic logic [2:0] decode(input logic [7:0] a);
		if (a == {cmp_ctrl_pkg::IDX_COMPARATOR_CONTROL[5:0], 2'b00}) begin
			decode = 3'h1;
		end else if (a == {cmp_ctrl_pkg::IDX_INPUT_SELECT_CONTROL[5:0], 2'b00}) begin
			decode = 3'h2;
		end else if (a == {cmp_ctrl_pkg::IDX_INTERRUPT_ENABLE_CONTROL[5:0], 2'b00}) begin
			decode = 3'h3;
		end else if (a == {cmp_ctrl_pkg::IDX_COMPARATOR_STATUS[5:0], 2'b00}) begin
			decode = 3'h4;
		end else begin
			decode = 3'h0;
		end
	endfunction

	// -------------------------------------------------------------
	// synchronisers and operating state
	// -------------------------------------------------------------
	// apart from the event_out path, the raw result meets only flip-flops; invert follows so every consumer sees it
	cmp_sync #(.W(4)) u_sync_misc (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({core_result, per_clk_request, sleep_mode}),
		.q     (misc_sync)
	);

	assign sleep_s     = cmp_ctrl_pkg::sleep_t'(misc_sync[1:0]);
	assign clk_held_s  = misc_sync[2];
	assign result_sync = misc_sync[3] ^ mux_reg.invert;

	// idle changes nothing; standby needs the run bit
	always_comb begin
		unit_on     = ctl_reg.enable;
		status_live = 1'b1;
		case (sleep_s)
			cmp_ctrl_pkg::SLEEP_STANDBY: begin
				unit_on     = ctl_reg.enable & ctl_reg.run_in_standby;
				status_live = clk_held_s;
			end
			cmp_ctrl_pkg::SLEEP_POWERDOWN: begin
				unit_on     = 1'b0;
				status_live = 1'b0;
			end
			default: begin
				unit_on     = ctl_reg.enable;
				status_live = 1'b1;
			end
		endcase
	end

	// -------------------------------------------------------------
	// core controls, start-up wait
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_enable           <= 1'b0;
			hysteresis_select     <= 2'h0;
			positive_input_select <= 1'b0;
			negative_input_select <= 2'h0;
			active_d_reg          <= 1'b0;
		end else begin
			core_enable           <= unit_on;
			hysteresis_select     <= ctl_reg.hysteresis_select;
			positive_input_select <= mux_reg.positive_input_select;
			negative_input_select <= mux_reg.negative_input_select;
			active_d_reg          <= unit_on;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_cnt_reg  <= '0;
			result_settled <= 1'b0;
		end else if (unit_on && !active_d_reg) begin
			if (mux_reg.negative_input_select == cmp_ctrl_pkg::NEG_VREF) begin
				start_cnt_reg <= VREF_STARTUP_CYCLES[cmp_ctrl_pkg::STARTUP_CNT_W-1:0];
			end else begin
				start_cnt_reg <= cmp_ctrl_pkg::CORE_STARTUP_CYC[cmp_ctrl_pkg::STARTUP_CNT_W-1:0];
			end
			result_settled <= 1'b0;
		end else if (!unit_on) begin
			start_cnt_reg  <= '0;
			result_settled <= 1'b0;
		end else if (start_cnt_reg != '0) begin
			start_cnt_reg  <= start_cnt_reg - 1'b1;
		end else begin
			result_settled <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// event and pad value paths: straight from the core, no clock; pad_oe_n is registered
	// -------------------------------------------------------------
	// core_result is high only when positive exceeds negative
	assign event_out = unit_on & (core_result ^ mux_reg.invert);
	assign pad_out   = event_out & ctl_reg.pad_output_enable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_oe_n <= 1'b1;
		end else begin
			pad_oe_n <= ~(unit_on & ctl_reg.pad_output_enable);
		end
	end

	// -------------------------------------------------------------
	// state bit, edge detection, flag and request
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= 1'b0;
		end else if (status_live) begin
			state_reg <= result_sync & unit_on;
		end
	end

	assign rise = result_sync & ~state_reg;
	assign fall = ~result_sync & state_reg;

	always_comb begin
		case (ctl_reg.interrupt_edge_select)
			cmp_ctrl_pkg::EDGE_BOTH:    edge_hit = rise | fall;
			cmp_ctrl_pkg::EDGE_FALLING: edge_hit = fall;
			cmp_ctrl_pkg::EDGE_RISING:  edge_hit = rise;
			default:                    edge_hit = 1'b0;
		endcase
	end

	assign stat_clear_w = do_write && decode(aw_addr_reg) == 3'h4 && w_lane_reg &&
		w_data_reg[cmp_ctrl_pkg::STAT_FLAG_BIT];
	assign stat_clear_r = do_read && decode(s_axi_araddr) == 3'h4;

	always_comb begin
		flag_next = flag_reg;
		if (stat_clear_w || stat_clear_r) begin
			flag_next = 1'b0;
		end
		if (status_live && unit_on && result_settled && edge_hit) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
			irq      <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			irq      <= flag_next & inte_reg[cmp_ctrl_pkg::STAT_FLAG_BIT];
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite write channel
	// -------------------------------------------------------------
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 8'h00;
			w_lane_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= cmp_ctrl_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (decode(aw_addr_reg) == 3'h0) ?
					cmp_ctrl_pkg::RESP_SLVERR : cmp_ctrl_pkg::RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software configures inputs before enable; nothing here enforces it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg  <= cmp_ctrl_pkg::comparator_control_t'(cmp_ctrl_pkg::CTL_RESET);
			mux_reg  <= cmp_ctrl_pkg::input_select_control_t'(cmp_ctrl_pkg::MUX_RESET);
			inte_reg <= cmp_ctrl_pkg::INTE_RESET;
		end else if (do_write && w_lane_reg) begin
			case (decode(aw_addr_reg))
				3'h1: ctl_reg <= cmp_ctrl_pkg::comparator_control_t'(
					w_data_reg & cmp_ctrl_pkg::CTL_MASK);
				3'h2: mux_reg <= cmp_ctrl_pkg::input_select_control_t'(
					w_data_reg & cmp_ctrl_pkg::MUX_MASK);
				3'h3: inte_reg <= w_data_reg & cmp_ctrl_pkg::INTE_MASK;
				default: ;
			endcase
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite read channel
	// -------------------------------------------------------------
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= cmp_ctrl_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !do_read;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= cmp_ctrl_pkg::RESP_OKAY;
				if (decode(s_axi_araddr) == 3'h1) begin
					s_axi_rdata <= {24'h000000, ctl_reg};
				end else if (decode(s_axi_araddr) == 3'h2) begin
					s_axi_rdata <= {24'h000000, mux_reg};
				end else if (decode(s_axi_araddr) == 3'h3) begin
					s_axi_rdata <= {24'h000000, inte_reg};
				end else if (decode(s_axi_araddr) == 3'h4) begin
					s_axi_rdata <= {27'h0000000, state_reg, 3'h0, flag_reg};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= cmp_ctrl_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	a_irq_follows_flag: assert property (@(posedge clk) disable iff (!rst_n)
		irq == ($past(flag_next) & $past(inte_reg[0])))
		else $error("request does not follow flag and enable");
	a_rise_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(status_live && unit_on && result_settled && rise &&
		ctl_reg.interrupt_edge_select == cmp_ctrl_pkg::EDGE_RISING) |=> flag_reg)
		else $error("rising edge did not set flag");
	a_edge_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		(ctl_reg.interrupt_edge_select == 2'h1 && !stat_clear_w && !stat_clear_r)
		|=> flag_reg == $past(flag_reg))
		else $error("reserved edge setting changed flag");
	a_clear_w1: assert property (@(posedge clk) disable iff (!rst_n)
		(stat_clear_w && !edge_hit) |=> !flag_reg)
		else $error("write of one did not clear flag");
	a_powerdown_off: assert property (@(posedge clk) disable iff (!rst_n)
		(sleep_s == cmp_ctrl_pkg::SLEEP_POWERDOWN) |-> !event_out ##1 (pad_oe_n && !core_enable))
		else $error("unit not off in power-down");
	a_standby_stop: assert property (@(posedge clk) disable iff (!rst_n)
		(sleep_s == cmp_ctrl_pkg::SLEEP_STANDBY && !ctl_reg.run_in_standby) |=> !core_enable)
		else $error("unit running in standby without run bit");
	a_state_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		(status_live && unit_on) |=> state_reg == $past(result_sync))
		else $error("state bit does not mirror result");
	a_startup_wait: assert property (@(posedge clk) disable iff (!rst_n)
		(unit_on && !active_d_reg) |=> !result_settled [*8])
		else $error("result settled too early");
	a_pad_drive: assert property (@(posedge clk) disable iff (!rst_n)
		(unit_on && ctl_reg.pad_output_enable) |=> !pad_oe_n)
		else $error("pad not driven when enabled");
endmodule // cmp_ctrl

// file: dv/comparator_core_model.sv
// file: behavioural model of the analog comparator core and its input pins
module comparator_core_model (
	input  wire logic        core_enable, // core powered
	input  wire logic        pos_sel,     // positive pin select
	input  wire logic [1:0]  neg_sel,     // negative source select
	input  wire logic [39:0] lvl,         // levels: ref, neg b, neg a, pos b, pos a
	output logic             core_result  // comparison result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] p;
	logic [7:0] n;
	always_comb begin
		p = pos_sel ? lvl[15:8] : lvl[7:0];
		n = (neg_sel == 2'h0) ? lvl[23:16] : (neg_sel == 2'h1) ? lvl[31:24] : lvl[39:32];
		core_result = core_enable & (p > n);
	end
endmodule // comparator_core_model

// file: dv/comparator_control_logic_tb_top.sv
// file: self-checking bench for the comparator control logic
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module comparator_control_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------
	// signals and instances
	// ---------------------------------------------
	logic        clk = 1'h0, rst_n = 1'h0, per_clk_request = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, hysteresis_select, negative_input_select;
	logic [1:0]  sleep_mode = 2'h0, resp;
	logic        core_result, core_enable, positive_input_select, result_settled;
	logic        event_out, pad_out, pad_oe_n, irq;
	logic [39:0] lvl = 40'h0;
	int          miscompares = 0;
	int          n_compared = 0;
	localparam int VREF_CYC = 20;
	always #4 clk = ~clk;
	cmp_ctrl #(.VREF_STARTUP_CYCLES(VREF_CYC)) cmp_ctrl_inst (.clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .core_result, .sleep_mode, .per_clk_request, .core_enable,
		.hysteresis_select, .positive_input_select, .negative_input_select,
		.result_settled, .event_out, .pad_out, .pad_oe_n, .irq);
	comparator_core_model comparator_core_model_inst (.core_enable,
		.pos_sel(positive_input_select), .neg_sel(negative_input_select), .lvl, .core_result);
	// ---------------------------------------------
	// bus tasks
	// ---------------------------------------------
	task automatic final_report();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		$display("BAD %0t wait ran out", $time);
		final_report();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) break;
		end
		if (n == 50) hang();
		s_axi_bready <= 1'h0;
		`CHK(resp, er)
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		logic ar, r;
		logic [31:0] dat;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid;
			dat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (r) break;
		end
		if (n == 50) hang();
		s_axi_rready <= 1'h0;
		`CHK(dat, {24'h0, e})
		`CHK(resp, er)
		@(posedge clk);
	endtask
	task automatic st(input logic [7:0] e);
		rd(8'h1C, e, cmp_ctrl_pkg::RESP_OKAY);
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_reset();
		rd(8'h00, 8'h00, 2'h0);
		rd(8'h08, 8'h00, 2'h0);
		rd(8'h18, 8'h00, 2'h0);
		st(8'h00);
		rd(8'h04, 8'h00, cmp_ctrl_pkg::RESP_SLVERR);
		wr(8'h20, 8'h01, cmp_ctrl_pkg::RESP_SLVERR);
	endtask
	task automatic t_start();
		int n;
		wr(8'h08, 8'h00, 2'h0);
		wr(8'h18, 8'h01, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		`CHK(core_enable, 1'h1)
		`CHK(result_settled, 1'h0)
		for (n = 0; n < 400 && result_settled !== 1'h1; n++) cyc(1);
		if (n == 400) hang();
		`CHK(n > 290, 1'h1)
		for (int h = 0; h < 4; h++) begin
			wr(8'h00, {5'h0, h[1:0], 1'h1}, 2'h0);
			cyc(2);
			`CHK(hysteresis_select, h[1:0])
		end
	endtask
	task automatic t_vref();
		int n;
		wr(8'h00, 8'h00, 2'h0);
		wr(8'h08, 8'h02, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		`CHK(result_settled, 1'h0)
		for (n = 0; n < 100 && result_settled !== 1'h1; n++) cyc(1);
		if (n == 100) hang();
		`CHK(n >= VREF_CYC && n < VREF_CYC + 3, 1'h1)
		wr(8'h08, 8'h00, 2'h0);
	endtask
	task automatic t_edges();
		logic [1:0] m [4] = '{cmp_ctrl_pkg::EDGE_BOTH, cmp_ctrl_pkg::EDGE_FALLING,
			cmp_ctrl_pkg::EDGE_RISING, 2'h1};
		logic up, dn;
		for (int i = 0; i < 4; i++) begin
			up = (m[i] == 2'h0) || (m[i] == 2'h3);
			dn = (m[i] == 2'h0) || (m[i] == 2'h2);
			wr(8'h00, {2'h0, m[i], 4'h1}, 2'h0);
			lvl[7:0] <= 8'h10;
			cyc(6);
			`CHK(irq, up)
			st({3'h0, 1'h1, 3'h0, up});
			cyc(2);
			`CHK(irq, 1'h0)
			lvl[7:0] <= 8'h00;
			cyc(6);
			st({7'h0, dn});
		end
		wr(8'h00, 8'h01, 2'h0);
		lvl[7:0] <= 8'h10;
		cyc(6);
		wr(8'h1C, 8'h00, 2'h0);
		`CHK(irq, 1'h1)
		wr(8'h18, 8'h00, 2'h0);
		cyc(2);
		`CHK(irq, 1'h0)
		wr(8'h1C, 8'h01, 2'h0);
		wr(8'h18, 8'h01, 2'h0);
		cyc(2);
		`CHK(irq, 1'h0)
	endtask
	task automatic t_select();
		lvl <= {8'h09, 8'h03, 8'h20, 8'h05, 8'h00};
		wr(8'h08, 8'h09, 2'h0);
		cyc(2);
		`CHK({positive_input_select, negative_input_select}, 3'h5)
		`CHK(event_out, 1'h1)
		wr(8'h08, 8'h0A, 2'h0);
		`CHK(event_out, 1'h0)
		lvl <= 40'h0;
		wr(8'h08, 8'h80, 2'h0);
		wr(8'h00, 8'h41, 2'h0);
		cyc(2);
		`CHK(event_out, 1'h1)
		`CHK(pad_out, 1'h1)
		`CHK(pad_oe_n, 1'h0)
		cyc(6);
		st(8'h11);
		wr(8'h08, 8'h00, 2'h0);
		cyc(6);
		st(8'h01);
	endtask
	task automatic t_sleep();
		wr(8'h00, 8'hC1, 2'h0);
		sleep_mode <= 2'h1;
		lvl[7:0] <= 8'h10;
		cyc(6);
		st(8'h11);
		sleep_mode <= 2'h2;
		lvl[7:0] <= 8'h00;
		cyc(6);
		`CHK(event_out, 1'h0)
		`CHK(irq, 1'h0)
		st(8'h10);
		per_clk_request <= 1'h1;
		cyc(6);
		st(8'h01);
		wr(8'h00, 8'h41, 2'h0);
		lvl[7:0] <= 8'h10;
		cyc(6);
		`CHK(event_out, 1'h0)
		sleep_mode <= 2'h3;
		wr(8'h00, 8'hC1, 2'h0);
		cyc(6);
		`CHK({core_enable, event_out, pad_out, pad_oe_n}, 4'h1)
		sleep_mode <= 2'h0;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset();
		t_start();
		t_vref();
		t_edges();
		t_select();
		t_sleep();
		final_report();
	end
endmodule // comparator_control_logic_tb_top
